// [hdl/mwc_pkg.sv]
package mwc_pkg;
    localparam logic [4:0] ADDR_FIXED      = 5'h1b;
    localparam logic [2:0] OP_MARGIN       = 3'h1;
    localparam logic [2:0] OP_WATCH        = 3'h3;
    localparam logic [4:0] VAL_NULL        = 5'h00;
    localparam int         VAL_SUPPLY_BIT  = 4;
    localparam int         VAL_SIGN_BIT    = 3;
    localparam int         VAL_WD_ON_BIT   = 3;
    localparam int         VAL_WD_RSVD_BIT = 4;
    localparam int         VAL_WD_WIN_BIT  = 2;
    localparam logic [1:0] WD_VAL_RSVD     = 2'h0;
    localparam int         CLK_HZ          = 125_000_000;
    localparam int         WD_MS_1280      = 1280;
    localparam int         WD_MS_320       = 320;
    localparam int         WD_MS_80        = 80;
    localparam int         WD_MS_20        = 20;
    localparam int         WD_CYC_1280     = WD_MS_1280 * (CLK_HZ / 1000);
    localparam int         WD_CYC_320      = WD_MS_320 * (CLK_HZ / 1000);
    localparam int         WD_CYC_80       = WD_MS_80 * (CLK_HZ / 1000);
    localparam int         WD_CYC_20       = WD_MS_20 * (CLK_HZ / 1000);
    localparam int         WD_CNT_W        = 28;

    typedef struct packed {
        logic       lower;
        logic [2:0] percent;
    } mwc_margin_t;

    typedef struct packed {
        logic       enabled;
        logic       windowed;
        logic [1:0] period_sel;
    } mwc_watch_cfg_t;

    typedef struct packed {
        logic [7:0] data;
    } mwc_byte_t;
endpackage : mwc_pkg

// [hdl/mwc_i2c_rx.sv]
`timescale 1ns/1ps
// write-only i2c receiver on the scl domain; bytes cross by toggle
module mwc_i2c_rx (
    input  wire logic       scl,
    input  wire logic       rst_b,
    input  wire logic       sda_in,
    input  wire logic [1:0] addr_strap,
    output logic            sda_oe_b,
    output logic            byte_tgl,
    output logic [7:0]      byte_data,
    output logic            start_tgl,
    output logic            stop_tgl
);
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       in_addr;
    logic       selected;
    logic       active;
    logic       start_seen;
    logic       stop_seen;

    // start/stop marks sampled by sda edges while scl high
    always_ff @(negedge sda_in or negedge rst_b) begin
        if (!rst_b) begin
            start_seen <= 1'b0;
        end else if (scl) begin
            start_seen <= ~start_seen;
        end
    end

    always_ff @(posedge sda_in or negedge rst_b) begin
        if (!rst_b) begin
            stop_seen <= 1'b0;
        end else if (scl) begin
            stop_seen <= ~stop_seen;
        end
    end

    assign start_tgl = start_seen;
    assign stop_tgl  = stop_seen;

    logic start_ack;
    always_ff @(posedge scl or negedge rst_b) begin
        if (!rst_b) begin
            start_ack <= 1'b0;
            bit_cnt   <= 4'h0;
            shreg     <= 8'h00;
            in_addr   <= 1'b0;
            selected  <= 1'b0;
            active    <= 1'b0;
            byte_tgl  <= 1'b0;
            byte_data <= 8'h00;
        end else begin
            if (start_ack != start_seen) begin
                start_ack <= start_seen;
                active    <= 1'b1;
                in_addr   <= 1'b1;
                selected  <= 1'b0;
                bit_cnt   <= 4'h1;
                shreg     <= {7'h00, sda_in};
            end else if (active) begin
                if (bit_cnt == 4'h8) begin
                    bit_cnt <= 4'h0;
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                    shreg   <= {shreg[6:0], sda_in};
                end
                if (bit_cnt == 4'h7) begin
                    if (in_addr) begin
                        // R16 R10
                        selected <= ({shreg[6:0], sda_in} ==
                                     {mwc_pkg::ADDR_FIXED, addr_strap, 1'b0});
                        active   <= ({shreg[6:0], sda_in} ==
                                     {mwc_pkg::ADDR_FIXED, addr_strap, 1'b0});
                        in_addr  <= 1'b0;
                    end else if (selected) begin
                        byte_data <= {shreg[6:0], sda_in};
                        byte_tgl  <= ~byte_tgl;
                    end
                end
            end
        end
    end

    // ack driven low during ninth clock
    always_ff @(negedge scl or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_b <= 1'b1;
        end else begin
            sda_oe_b <= ~(active && selected && bit_cnt == 4'h8);
        end
    end
endmodule : mwc_i2c_rx

// [hdl/mwc_cmd_slave.sv]
`timescale 1ns/1ps
// Behaviour
// R1 - master sends margining first command, then a supply's margin byte
// R2 - two margining bytes after one first command are both applied
// R3 - master periodically refreshes with watchdog first command and byte
// R4 - valid watchdog byte after watchdog first command starts timer
// R5 - refresh inside open window clears timer and loads new period
// R6 - watchdog first command twice in a row stops and disables timer
// R7 - after disable, any valid watchdog byte restarts with its period
// R8 - only the master ends a transfer, with stop
// R9 - stop returns to idle and drops partial command sequence
// R10 - write-only slave: address with rw zero, then command bytes
// R11 - margining value 00101 sets linear regulator five percent high
// R12 - margining 001 11100 sets switcher four percent low
// R13 - value: supply bit, sign bit, three-bit percent magnitude
// R14 - watchdog value: zero off, else on, window bit, period select
// R15 - byte is 3-bit operation plus 5-bit value; first command precedes
// R16 - two low address bits come from strap pins
// R17 - expiry raises timeout; early windowed refresh is flagged
// R18 - unknown or unprefixed bytes are ignored, settings unchanged
module mwc_cmd_slave #(
    parameter int unsigned CYC_1280 = mwc_pkg::WD_CYC_1280,
    parameter int unsigned CYC_320  = mwc_pkg::WD_CYC_320,
    parameter int unsigned CYC_80   = mwc_pkg::WD_CYC_80,
    parameter int unsigned CYC_20   = mwc_pkg::WD_CYC_20
) (
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 scl,
    input  wire logic                 sda_in,
    output logic                      sda_oe_b,
    input  wire logic                 slave_id_strap_b1,
    input  wire logic                 slave_id_strap_b0,
    output mwc_pkg::mwc_margin_t      ldo_margin,
    output mwc_pkg::mwc_margin_t      sw_margin,
    output mwc_pkg::mwc_watch_cfg_t   watch_cfg,
    output logic                      supervision_timer_expired,
    output logic                      early_refresh
);
    typedef enum logic [1:0] {
        MWC_IDLE,
        MWC_MARGIN,
        MWC_WATCH
    } mwc_state_t;

    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap;
    logic       rx_oe_b;
    logic       rx_byte_tgl;
    logic       rx_start_tgl;
    logic       rx_stop_tgl;
    mwc_pkg::mwc_byte_t rx_byte;

    // straps synchronised through three flops and resampled every clock
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_s1 <= 2'h0;
            strap_s2 <= 2'h0;
            strap    <= 2'h0;
        end else begin
            strap_s1 <= {slave_id_strap_b1, slave_id_strap_b0};
            strap_s2 <= strap_s1;
            strap    <= strap_s2;
        end
    end

    mwc_i2c_rx u_rx (
        .scl        (scl),
        .rst_b      (rst_b),
        .sda_in     (sda_in),
        .addr_strap (strap),
        .sda_oe_b   (rx_oe_b),
        .byte_tgl   (rx_byte_tgl),
        .byte_data  (rx_byte.data),
        .start_tgl  (rx_start_tgl),
        .stop_tgl   (rx_stop_tgl)
    );

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sda_oe_b <= 1'b1;
        end else begin
            sda_oe_b <= rx_oe_b;
        end
    end

    // toggle crossings; byte data is stable long before its toggle lands
    logic [2:0] byte_sync;
    logic [2:0] start_sync;
    logic [2:0] stop_sync;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            byte_sync  <= 3'h0;
            start_sync <= 3'h0;
            stop_sync  <= 3'h0;
        end else begin
            byte_sync  <= {byte_sync[1:0], rx_byte_tgl};
            start_sync <= {start_sync[1:0], rx_start_tgl};
            stop_sync  <= {stop_sync[1:0], rx_stop_tgl};
        end
    end

    logic       byte_ev;
    logic       frame_ev;
    logic [2:0] op;
    logic [4:0] val;
    assign byte_ev  = byte_sync[2] ^ byte_sync[1];
    assign frame_ev = (stop_sync[2] ^ stop_sync[1]) | (start_sync[2] ^ start_sync[1]);
    assign op       = rx_byte.data[7:5];
    assign val      = rx_byte.data[4:0];

    mwc_state_t state;
    logic       prev_watch_first;
    logic       wd_load;
    logic       wd_off;
    logic       wd_valid;

    // top value bit stays clear on every defined watchdog setting
    assign wd_valid = val[mwc_pkg::VAL_WD_ON_BIT] &&
                      !val[mwc_pkg::VAL_WD_RSVD_BIT]; // R14 R18

    // command sequencer
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state            <= MWC_IDLE;
            prev_watch_first <= 1'b0;
        end else if (frame_ev) begin
            state            <= MWC_IDLE; // R9
            prev_watch_first <= 1'b0;
        end else if (byte_ev) begin
            prev_watch_first <= (op == mwc_pkg::OP_WATCH && val == mwc_pkg::VAL_NULL);
            case (state)
                MWC_IDLE: begin
                    if (op == mwc_pkg::OP_MARGIN && val == mwc_pkg::VAL_NULL) begin
                        state <= MWC_MARGIN; // R15 R1
                    end else if (op == mwc_pkg::OP_WATCH && val == mwc_pkg::VAL_NULL) begin
                        state <= MWC_WATCH;
                    end
                end
                MWC_MARGIN: begin
                    if (op != mwc_pkg::OP_MARGIN) begin
                        state <= MWC_IDLE; // R18
                    end
                end
                MWC_WATCH: begin
                    state <= MWC_IDLE;
                end
                default: state <= MWC_IDLE;
            endcase
        end
    end

    // margin settings; several bytes may follow one first command
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ldo_margin <= '0;
            sw_margin  <= '0;
        end else if (byte_ev && !frame_ev && state == MWC_MARGIN &&
                     op == mwc_pkg::OP_MARGIN) begin // R2
            if (val[mwc_pkg::VAL_SUPPLY_BIT]) begin
                sw_margin  <= val[3:0]; // R12 R13
            end else begin
                ldo_margin <= val[3:0]; // R11 R13
            end
        end
    end

    assign wd_off  = byte_ev && !frame_ev && state == MWC_WATCH && prev_watch_first &&
                     op == mwc_pkg::OP_WATCH && val == mwc_pkg::VAL_NULL; // R6
    assign wd_load = byte_ev && !frame_ev && state == MWC_WATCH &&
                     op == mwc_pkg::OP_WATCH && wd_valid; // R4 R7

    logic [mwc_pkg::WD_CNT_W-1:0] wd_cnt;
    logic [mwc_pkg::WD_CNT_W-1:0] wd_limit;
    always_comb begin
        case (watch_cfg.period_sel)
            2'h0:    wd_limit = mwc_pkg::WD_CNT_W'(CYC_1280);
            2'h1:    wd_limit = mwc_pkg::WD_CNT_W'(CYC_320);
            2'h2:    wd_limit = mwc_pkg::WD_CNT_W'(CYC_80);
            default: wd_limit = mwc_pkg::WD_CNT_W'(CYC_20);
        endcase
    end

    // window opens at half the period; earlier refresh is flagged, not taken
    logic window_open;
    assign window_open = !watch_cfg.windowed || !watch_cfg.enabled ||
                         (wd_cnt >= (wd_limit >> 1));

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            watch_cfg <= '0;
            wd_cnt    <= '0;
        end else if (wd_off) begin
            watch_cfg <= '0; // R6
            wd_cnt    <= '0;
        end else if (wd_load && window_open) begin
            watch_cfg <= {1'b1, val[mwc_pkg::VAL_WD_WIN_BIT], val[1:0]}; // R5
            wd_cnt    <= '0;
        end else if (watch_cfg.enabled) begin
            wd_cnt    <= (wd_cnt >= wd_limit) ? '0 : wd_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            supervision_timer_expired <= 1'b0;
            early_refresh             <= 1'b0;
        end else begin
            supervision_timer_expired <= watch_cfg.enabled && !wd_load && !wd_off &&
                                         wd_cnt >= wd_limit; // R17
            early_refresh             <= wd_load && !window_open; // R17
        end
    end
endmodule : mwc_cmd_slave

// [tb/mwc_i2c_master.sv]
`timescale 1ns/1ps
// bus master model; scl parks high between frames
module mwc_i2c_master (
    output logic      scl = 1'b1,
    output logic      sda_drv = 1'b1,
    input  wire logic sda
);
    task automatic start();
        #7.5 sda_drv = 1'b0;
        #7.5 scl = 1'b0;
    endtask : start

    // data moves only while scl is low
    task automatic send(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #2 sda_drv = d[i];
            #5.5 scl = 1'b1;
            #7.5 scl = 1'b0;
        end
        // 1 releases the line to its pull-up
        #2 sda_drv = 1'b1;
        // long ack slot: the slave's answer passes a clock crossing
        #28 scl = 1'b1;
        ack = ~sda;
        #7.5 scl = 1'b0;
        #30;
    endtask : send

    task automatic stop();
        #2 sda_drv = 1'b0;
        #5.5 scl = 1'b1;
        #7.5 sda_drv = 1'b1;
        #7.5;
    endtask : stop
endmodule : mwc_i2c_master

// [tb/mwc_cmd_slave_asserts.sv]
`timescale 1ns/1ps
module mwc_cmd_slave_asserts #(
    parameter int unsigned CYC_1280 = mwc_pkg::WD_CYC_1280,
    parameter int unsigned CYC_320  = mwc_pkg::WD_CYC_320,
    parameter int unsigned CYC_80   = mwc_pkg::WD_CYC_80,
    parameter int unsigned CYC_20   = mwc_pkg::WD_CYC_20
) (
    input wire logic                    sys_clk,
    input wire logic                    rst_b,
    input wire logic                    scl,
    input wire logic                    sda_oe_b,
    input wire mwc_pkg::mwc_margin_t    ldo_margin,
    input wire mwc_pkg::mwc_margin_t    sw_margin,
    input wire mwc_pkg::mwc_watch_cfg_t watch_cfg,
    input wire logic                    supervision_timer_expired,
    input wire logic                    early_refresh
);
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    property p_rst;
        $rose(rst_b) |-> sda_oe_b && ldo_margin == 4'h0 && sw_margin == 4'h0 && watch_cfg == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("not idle after reset");
    property p_ack_low; $fell(sda_oe_b) |-> !scl; endproperty
    a_ack_low: assert property (p_ack_low) else $error("ack not in low phase");
    property p_ack_len; $fell(sda_oe_b) |-> !sda_oe_b [*2] ##[1:12] sda_oe_b; endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack length wrong");
    property p_exp; supervision_timer_expired |=> !supervision_timer_expired [*8]; endproperty
    a_exp: assert property (p_exp) else $error("expiry pulse too close");
    property p_exp_en; supervision_timer_expired |-> watch_cfg.enabled; endproperty
    a_exp_en: assert property (p_exp_en) else $error("expiry while off");
    property p_early; early_refresh |-> watch_cfg.enabled && watch_cfg.windowed; endproperty
    a_early: assert property (p_early) else $error("early flag outside window mode");
    property p_early_keep; early_refresh |=> $stable(watch_cfg) [*3]; endproperty
    a_early_keep: assert property (p_early_keep) else $error("early refresh applied");
    property p_ldo_hold; $changed(ldo_margin) |=> $stable(ldo_margin) [*8]; endproperty
    a_ldo_hold: assert property (p_ldo_hold) else $error("margin changed twice");
    c_exp: cover property (supervision_timer_expired);
    c_early: cover property (early_refresh);
    c_ack: cover property ($fell(sda_oe_b));
endmodule : mwc_cmd_slave_asserts

bind mwc_cmd_slave mwc_cmd_slave_asserts #(
    .CYC_1280(CYC_1280), .CYC_320(CYC_320), .CYC_80(CYC_80), .CYC_20(CYC_20)
) u_chk (.*);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
    logic                    sys_clk = 1'b0;
    logic                    rst_b = 1'b1;
    logic                    s1;
    logic                    s0;
    logic                    scl;
    logic                    sda_drv;
    logic                    sda_oe_b;
    logic                    ack;
    logic                    t_exp;
    logic                    t_early;
    mwc_pkg::mwc_margin_t    ldo;
    mwc_pkg::mwc_margin_t    sw;
    mwc_pkg::mwc_watch_cfg_t cfg;
    logic [11:0]             st = 12'h000;
    logic [11:0]             prev = 12'h000;
    logic [23:0]             e;
    logic [23:0]             q[$];
    logic [7:0]              adr;
    logic [4:0]              v;
    logic [31:0]             rnd = 32'hd460_757b;
    int                      fails = 0;
    int                      total_checks = 0;
    int                      n_exp = 0;
    int                      n_early = 0;
    int                      base_exp;
    int                      base_early;

    always #4 sys_clk = ~sys_clk;
    mwc_i2c_master m (.scl(scl), .sda_drv(sda_drv), .sda(sda_drv & sda_oe_b));
    // short periods keep the run small
    mwc_cmd_slave #(.CYC_1280(400), .CYC_320(100), .CYC_80(50), .CYC_20(20)) dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .scl(scl), .sda_in(sda_drv & sda_oe_b),
        .sda_oe_b(sda_oe_b), .slave_id_strap_b1(s1), .slave_id_strap_b0(s0),
        .ldo_margin(ldo), .sw_margin(sw), .watch_cfg(cfg),
        .supervision_timer_expired(t_exp), .early_refresh(t_early));

    task automatic chk(input logic [11:0] g, input logic [11:0] x, input logic [11:0] k);
        total_checks++;
        if ((g & k) !== (x & k)) begin
            fails++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
        end
    endtask : chk
    task automatic ok(input logic c);
        chk({11'h000, c}, 12'h001, 12'h001);
    endtask : ok

    // a setting change with no note queued is a failure
    always @(posedge sys_clk) begin
        n_exp <= n_exp + int'(t_exp === 1'b1);
        n_early <= n_early + int'(t_early === 1'b1);
        prev <= {ldo, sw, cfg};
        if (rst_b && {ldo, sw, cfg} !== prev) begin
            e = (q.size() > 0) ? q.pop_front() : {prev, 12'hfff};
            chk({ldo, sw, cfg}, e[23:12], e[11:0]);
        end
    end

    task automatic put(input logic [11:0] x, input logic [11:0] k);
        if ((x & k) !== (st & k)) q.push_back({x, k});
        st = x;
    endtask : put
    task automatic xfer(input logic [7:0] a, input logic [23:0] b, input int n, input logic w);
        m.start();
        m.send(a, ack);
        ok(ack === w);
        for (int i = 0; i < n; i++) m.send(b[23-8*i -: 8], ack);
        m.stop();
        repeat (2) @(negedge sys_clk);
    endtask : xfer
    // zero nibble sends the first command twice
    task automatic wd(input logic [3:0] nb);
        put({st[11:4], nb}, nb == 4'h0 ? 12'h008 : 12'hfff);
        xfer(adr, {8'h60, 4'h6, nb, 8'h00}, 2, 1'b1);
    endtask : wd
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic end_sim();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim

    initial begin
        // a real falling edge, so the scl-clocked receiver resets as well
        #1 rst_b = 1'b0;
        rnd = xs(rnd);
        s1 = rnd[0];
        s0 = rnd[1];
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        adr = {mwc_pkg::ADDR_FIXED, s1, s0, 1'b0};
        repeat (6) @(negedge sys_clk);
        chk({ldo, sw, cfg}, 12'h000, 12'hfff);
        ok(sda_oe_b === 1'b1);
        xfer(adr ^ 8'h02, 24'h20_2500, 2, 1'b0);
        xfer(adr | 8'h01, 24'h20_2500, 2, 1'b0);
        xfer(adr, 24'h25_3c00, 2, 1'b1);
        xfer(adr, 24'h20_6800, 2, 1'b1);
        xfer(adr, 24'h40_4500, 2, 1'b1);
        xfer(adr, 24'h20_0000, 1, 1'b1);
        xfer(adr, 24'h25_0000, 1, 1'b1);
        put({4'h5, st[7:0]}, 12'hfff);
        put({4'h5, 4'hc, st[3:0]}, 12'hfff);
        xfer(adr, 24'h20_253c, 3, 1'b1);
        for (int i = 0; i < 8; i++) begin
            rnd = xs(rnd);
            v = rnd[4:0];
            if (v[3:0] == 4'h0 || v[3:0] == 4'hf) v[3:0] = 4'h7;
            put(v[4] ? {st[11:8], v[3:0], st[3:0]} : {v[3:0], st[7:0]}, 12'hfff);
            xfer(adr, {8'h20, 3'h1, v, 8'h00}, 2, 1'b1);
        end
        for (int i = 8; i < 16; i++) begin
            wd(4'h0);
            wd(4'(i));
        end
        wd(4'h0);
        wd(4'hc);
        base_early = n_early;
        xfer(adr, 24'h60_6d00, 2, 1'b1);
        ok(n_early - base_early == 1);
        wd(4'h0);
        wd(4'hb);
        base_exp = n_exp;
        repeat (50) @(negedge sys_clk);
        ok(n_exp - base_exp inside {[2:3]});
        wd(4'h8);
        base_exp = n_exp;
        repeat (300) @(negedge sys_clk);
        ok(n_exp - base_exp == 0);
        wd(4'h0);
        base_exp = n_exp;
        repeat (60) @(negedge sys_clk);
        ok(n_exp - base_exp == 0);
        for (int k = 0; k < 50 && q.size() > 0; k++) @(negedge sys_clk);
        ok(q.size() == 0);
        end_sim();
    end
endmodule : tb
